// ---- core/dispense_job_handshake.v ----
// Job sequencing and precharge selection for one metering channel.
// Assumes handshake inputs come from an external controller, unsynced
// in practice, and style tables are loaded over the config ports.
`default_nettype none
`include "job_handshake_consts.vh"
module dispense_job_handshake #(
  parameter NV           = `NUM_VALVES,
  parameter CLK_PER_MS   = `MS_DIV,
  parameter PREP_MS      = `CABLE_PREP_MS,
  parameter GAP_MS       = `JOB_GAP_MS,
  parameter HELD_MS      = `ADV_HELD_MS
) (
  input  wire                 i_sys_clk,
  input  wire                 i_rst_n,
  input  wire [`STYLE_W-1:0]  i_style,         // Style code
  input  wire                 i_style_strobe,  // Job start request
  input  wire                 i_job_done,      // Job-done request
  input  wire [NV-1:0]        i_valve_on,      // Valve open requests
  input  wire [NV-1:0]        i_pc_req,        // Gateway precharge bits
  input  wire                 i_cable_trig,    // Command cable trigger
  input  wire                 i_cable_mode,    // Cable trigger selected
  input  wire                 i_timer_end,     // Timer job-end selected
  input  wire [15:0]          i_end_ms,        // Job-end timer preset
  input  wire [1:0]           i_pc_mode,       // Precharge mode
  input  wire                 i_gw_present,    // Fieldbus fitted
  input  wire [15:0]          i_open_ms,       // Opening scaling time
  input  wire                 i_cfg_we,        // Style table write
  input  wire [`STYLE_W-1:0]  i_cfg_style,     // Style to write
  input  wire [`VOL_W-1:0]    i_cfg_target,    // Target volume
  input  wire [`TOL_W-1:0]    i_cfg_tol,       // Tolerance percent
  input  wire [`VOL_W-1:0]    i_meas_vol,      // Measured volume
  input  wire                 i_alarm,         // Alarm present
  output reg                  o_plate_ready,   // Ready for a job
  output reg                  o_job_active,    // Job in progress
  output reg  [`STYLE_W-1:0]  o_style_echo,    // Echoed style code
  output reg  [`STYLE_W-1:0]  o_job_style,     // Style of this job
  output reg                  o_purge,         // Job is a purge
  output reg                  o_no_alarm,      // Result: no alarm
  output reg                  o_no_error,      // Result: no error
  output reg                  o_vol_ok,        // Result: in tolerance
  output reg                  o_error,         // Result: error
  output reg  [`VOL_W-1:0]    o_disp_vol,      // Result: volume
  output reg                  o_advisory,      // Handshake misuse
  output reg                  o_hold_static,   // Hold precharge pressure
  output reg  [1:0]           o_scale_sel,     // Scaling in force
  output reg  [NV-1:0]        o_scale_valves   // Valves whose scaling
);
  localparam S_IDLE = 4'b0001;  // Waiting for strobe
  localparam S_PREP = 4'b0010;  // Cable job preparing
  localparam S_RUN  = 4'b0100;  // Job running
  localparam S_DONE = 4'b1000;  // Processing gap

  reg [3:0]          state_reg;
  reg [NV-1:0]       v_s1, v_s2, v_d;     // Valve sync and delay
  reg [NV-1:0]       p_s1, p_s2;          // Precharge bit sync
  reg [2:0]          h_s1, h_s2, h_d;     // Strobe, done, cable
  reg [`STYLE_W-1:0] sty_s1, sty_s2;      // Style sync
  reg [`VOL_W-1:0]   tgt_mem [0:255];     // Target per style
  reg [`TOL_W-1:0]   tol_mem [0:255];     // Tolerance per style
  reg                done_seen_reg;       // Done rose this job
  reg                opening_reg;         // Opening window live
  reg                fin_reg;             // Results written, active drop pending

  wire strobe   = h_s2[0];
  wire str_rise = h_s2[0] & ~h_d[0];
  wire str_fall = ~h_s2[0] & h_d[0];
  wire done_r   = h_s2[1] & ~h_d[1];
  wire cab_rise = h_s2[2] & ~h_d[2];
  wire any_open = |v_s2;
  wire open_r   = |(v_s2 & ~v_d);
  wire closing  = |(~v_s2 & v_d);
  wire running  = state_reg == S_RUN;

  // Shared timers: job-end, opening window, prep/gap, held-done
  wire end_exp, open_exp, wait_exp, held_exp;
  ms_timer #(.CLK_PER_MS(CLK_PER_MS), .MS_W(16)) u_end (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_restart(closing | open_r),
    // Cable jobs have no done request, so the timer is enabled there whatever i_timer_end says
    .i_run(running & (i_timer_end | i_cable_mode) & ~any_open),
    .i_preset_ms(i_end_ms), .o_expired(end_exp));
  ms_timer #(.CLK_PER_MS(CLK_PER_MS), .MS_W(16)) u_open (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_restart(open_r), .i_run(opening_reg),
    .i_preset_ms(i_open_ms - 16'h0001), .o_expired(open_exp));
  ms_timer #(.CLK_PER_MS(CLK_PER_MS), .MS_W(16)) u_wait (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_restart(1'b0),
    .i_run(state_reg == S_PREP || state_reg == S_DONE),
    .i_preset_ms(state_reg == S_PREP ? PREP_MS[15:0] - 16'h0001
                                     : GAP_MS[15:0] - 16'h0001),
    .o_expired(wait_exp));
  ms_timer #(.CLK_PER_MS(CLK_PER_MS), .MS_W(16)) u_held (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_restart(1'b0), .i_run(h_s2[1]),
    .i_preset_ms(HELD_MS[15:0]), .o_expired(held_exp));

  // Tolerance check of measured against captured target
  function in_tol;
    input [`VOL_W-1:0] meas;
    input [`VOL_W-1:0] tgt;
    input [`TOL_W-1:0] tol;
    reg   [`VOL_W+7:0] band;
    begin
      band   = (tgt * tol) / `PCT_FULL;
      in_tol = ({8'h00, meas} + band >= {8'h00, tgt}) &&
               ({8'h00, meas} <= {8'h00, tgt} + band);
    end
  endfunction

  // Two-flop input synchronisers and edge delay
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      v_s1 <= {NV{1'b0}}; v_s2 <= {NV{1'b0}}; v_d <= {NV{1'b0}};
      p_s1 <= {NV{1'b0}}; p_s2 <= {NV{1'b0}};
      h_s1 <= 3'h0; h_s2 <= 3'h0; h_d <= 3'h0;
      sty_s1 <= 8'h00; sty_s2 <= 8'h00;
    end
    else
    begin
      v_s1 <= i_valve_on;  v_s2 <= v_s1;  v_d <= v_s2;
      p_s1 <= i_pc_req;    p_s2 <= p_s1;
      h_s1 <= {i_cable_trig, i_job_done, i_style_strobe};
      h_s2 <= h_s1;        h_d <= h_s2;
      sty_s1 <= i_style;   sty_s2 <= sty_s1;
    end
  end

  // Per-style target and tolerance tables
  always @(posedge i_sys_clk)
  begin
    if (i_cfg_we)
    begin
      tgt_mem[i_cfg_style] <= i_cfg_target;
      tol_mem[i_cfg_style] <= i_cfg_tol;
    end
  end

  // Job sequencer
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= S_IDLE;
      o_plate_ready <= 1'b0; o_job_active <= 1'b0;
      o_style_echo <= 8'h00; o_job_style <= 8'h00; o_purge <= 1'b0;
      o_no_alarm <= 1'b1; o_no_error <= 1'b1; o_vol_ok <= 1'b0;
      o_error <= 1'b0; o_disp_vol <= 24'h000000; o_advisory <= 1'b0;
      done_seen_reg <= 1'b0; fin_reg <= 1'b0;
    end
    else
    begin
      o_style_echo <= sty_s2;
      // Advisory: done held too long, or strobe dropped first
      if (held_exp || (running && str_fall && !done_seen_reg))
        o_advisory <= 1'b1;
      else if (str_rise)
        o_advisory <= 1'b0;
      if (fin_reg)
      begin
        // Results first, job-active drops next cycle
        fin_reg <= 1'b0;
        o_job_active <= 1'b0;
        state_reg <= S_DONE;
      end
      else
        case (state_reg)
          S_IDLE:
          begin
            o_plate_ready <= ~strobe & ~h_s2[1];
            if (str_rise && o_plate_ready && !i_cable_mode)
            begin
              o_job_style <= sty_s2;
              o_purge <= (sty_s2 == `PURGE_STYLE);
              o_job_active <= 1'b1;
              o_plate_ready <= 1'b0;
              done_seen_reg <= 1'b0;
              state_reg <= S_RUN;
            end
            else if (cab_rise && o_plate_ready && i_cable_mode)
            begin
              o_job_style <= `CABLE_STYLE;
              o_purge <= 1'b0;
              o_job_active <= 1'b1;
              o_plate_ready <= 1'b0;
              state_reg <= S_PREP;
            end
          end
          S_PREP:
            if (wait_exp)
              state_reg <= S_RUN;
          S_RUN:
          begin
            if (done_r)
              done_seen_reg <= 1'b1;
            // Cable jobs end only by timer
            if ((i_cable_mode && end_exp) ||
                (!i_cable_mode && (done_r || str_fall ||
                 (i_timer_end && end_exp))))
            begin
              fin_reg    <= 1'b1;
              o_no_alarm <= ~i_alarm;
              o_vol_ok   <= in_tol(i_meas_vol,
                            tgt_mem[o_job_style], tol_mem[o_job_style]);
              o_no_error <= in_tol(i_meas_vol,
                            tgt_mem[o_job_style], tol_mem[o_job_style]);
              o_error    <= ~in_tol(i_meas_vol,
                            tgt_mem[o_job_style], tol_mem[o_job_style]);
              o_disp_vol <= i_meas_vol;
            end
          end
          S_DONE:
            if (wait_exp)
              state_reg <= S_IDLE;
          default:
            state_reg <= S_IDLE;
        endcase
    end
  end

  // Precharge scaling selection
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      opening_reg <= 1'b0; o_hold_static <= 1'b0;
      o_scale_sel <= `SEL_UNSCALED; o_scale_valves <= {NV{1'b0}};
    end
    else
    begin
      if (open_r)
        opening_reg <= 1'b1;
      else if (open_exp || !any_open)
        opening_reg <= 1'b0;
      // Static mode: hold pressure only while all closed
      o_hold_static <= o_job_active && !any_open &&
                       (i_pc_mode == `MODE_STATIC);
      if (!o_job_active)
        o_scale_sel <= `SEL_UNSCALED;
      else if (i_pc_mode == `MODE_STATIC)
        o_scale_sel <= any_open ? `SEL_UNSCALED : `SEL_STATIC;
      else if (!any_open)
        o_scale_sel <= `SEL_CLOSED;
      else if (opening_reg && !open_exp)
        o_scale_sel <= `SEL_OPENING;
      else
        o_scale_sel <= `SEL_UNSCALED;
      if (i_pc_mode == `MODE_VALVE1)
        o_scale_valves <= {{(NV-1){1'b0}}, 1'b1};
      else if (i_pc_mode == `MODE_GATEWAY && i_gw_present)
        o_scale_valves <= p_s2;
      else
        o_scale_valves <= v_s2;
    end
  end
endmodule
`default_nettype wire

// ---- core/job_handshake_consts.vh ----
// Constants for the dispense job handshake block.
// Assumes a single 20 MHz system clock; included by bare name.
`ifndef JOB_HANDSHAKE_CONSTS_VH
`define JOB_HANDSHAKE_CONSTS_VH
`define CLK_HZ             20000000
`define STYLE_W            8
`define PURGE_STYLE        8'h00
`define CABLE_STYLE        8'h01
`define NUM_VALVES         4
`define SCALE_W            16
`define VOL_W              24
`define TOL_W              8
`define MS_DIV             32'd20000
`define CABLE_PREP_MS      100
`define JOB_GAP_MS         1250
`define ADV_HELD_MS        500
`define PCT_FULL           100
`define MODE_STATIC        2'h0
`define MODE_DYNAMIC       2'h1
`define MODE_VALVE1        2'h2
`define MODE_GATEWAY       2'h3
`define SEL_UNSCALED       2'h0
`define SEL_CLOSED         2'h1
`define SEL_OPENING        2'h2
`define SEL_STATIC         2'h3
`endif

// ---- core/ms_timer.v ----
// Millisecond up-counter with restart; expires after a preset count.
// Assumes one system clock and a synchronous active-low reset.
`default_nettype none
`include "job_handshake_consts.vh"
module ms_timer #(
  parameter CLK_PER_MS = `MS_DIV,
  parameter MS_W       = 16
) (
  input  wire            i_sys_clk,
  input  wire            i_rst_n,
  input  wire            i_restart,   // Reload and start counting
  input  wire            i_run,       // Count while high
  input  wire [MS_W-1:0] i_preset_ms, // Time to expire
  output reg             o_expired    // Level, high once time elapsed
);
  reg [31:0]     tick_reg;            // Cycles inside one ms
  reg [MS_W-1:0] ms_reg;              // Whole ms elapsed

  // Prescaler and ms count; restart wins over counting
  always @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      tick_reg  <= 32'h00000000;
      ms_reg    <= {MS_W{1'b0}};
      o_expired <= 1'b0;
    end
    else if (i_restart || !i_run)
    begin
      tick_reg  <= 32'h00000000;
      ms_reg    <= {MS_W{1'b0}};
      o_expired <= 1'b0;
    end
    else if (!o_expired)
    begin
      if (tick_reg == CLK_PER_MS - 1)
      begin
        tick_reg <= 32'h00000000;
        ms_reg   <= ms_reg + 1'b1;
      end
      else
        tick_reg <= tick_reg + 32'h00000001;
      // Strictly longer than preset before expiry
      if (ms_reg > i_preset_ms)
        o_expired <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- verif/auto_ctrl_model.sv ----
// Automation controller model driving the job handshake lines.
// Assumes the bench calls run_job; lines change on falling edges.
`default_nettype none
module auto_ctrl_model #(
  parameter NV    = 4,
  parameter SPACE = 2  // Cycles between style and strobe changes
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_plate_ready,
  input  wire logic          i_job_active,
  output var  logic [7:0]    o_style,
  output var  logic          o_strobe,
  output var  logic          o_done,
  output var  logic [NV-1:0] o_valves
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels before any job
  initial
  begin
    o_style = 8'h00;
    o_strobe = 1'b0;
    o_done = 1'b0;
    o_valves = {NV{1'b0}};
  end
  // Bounded wait for ready (rdy) or active to reach a level
  task automatic wait_on(input logic rdy, input logic lvl, input int lim);
    int n;
    n = 0;
    while ((rdy ? i_plate_ready : i_job_active) !== lvl && n < lim)
    begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask
  // Kind 0 done pulse, 1 strobe drop, 2 timer end, 3 done held long
  task automatic run_job(input logic [7:0] sty, input logic [NV-1:0] pat,
                         input int kind);
    wait_on(1'b1, 1'b1, 3000);
    o_style = sty;
    // Spacing is token only: the bench millisecond is shortened
    repeat (SPACE) @(negedge i_sys_clk);
    o_strobe = 1'b1;
    wait_on(1'b0, 1'b1, 20);
    o_style = ~sty; // Late change, must not reach this job
    o_valves = pat;
    repeat (30) @(negedge i_sys_clk);
    o_valves = {NV{1'b0}};
    repeat (4) @(negedge i_sys_clk);
    if (kind == 1)
      o_strobe = 1'b0;
    else if (kind != 2)
      o_done = 1'b1;
    wait_on(1'b0, 1'b0, 200);
    if (kind == 3)
      repeat (80) @(negedge i_sys_clk);
    o_done = 1'b0;
    @(negedge i_sys_clk);
    o_strobe = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/job_handshake_sva.sv ----
// Assertion checker for the job handshake block, bound to its ports.
// Assumes the constants header is on the include path.
`default_nettype none
`include "job_handshake_consts.vh"
module job_handshake_sva #(
  parameter NV = 4
) (
  input wire logic                i_sys_clk,
  input wire logic                i_rst_n,
  input wire logic [`STYLE_W-1:0] i_style,
  input wire logic                i_style_strobe,
  input wire logic                i_job_done,
  input wire logic [NV-1:0]       i_valve_on,
  input wire logic [NV-1:0]       i_pc_req,
  input wire logic [1:0]          i_pc_mode,
  input wire logic                i_alarm,
  input wire logic                i_cable_mode,
  input wire logic [`VOL_W-1:0]   i_meas_vol,
  input wire logic                o_plate_ready,
  input wire logic                o_job_active,
  input wire logic [`STYLE_W-1:0] o_style_echo,
  input wire logic [`STYLE_W-1:0] o_job_style,
  input wire logic                o_purge,
  input wire logic                o_no_alarm,
  input wire logic                o_no_error,
  input wire logic                o_vol_ok,
  input wire logic [`VOL_W-1:0]   o_disp_vol,
  input wire logic                o_hold_static,
  input wire logic [1:0]          o_scale_sel,
  input wire logic [NV-1:0]       o_scale_valves
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Job running with every valve closed
  wire logic shut = o_job_active && !(|i_valve_on);

  a_start_cause: assert property (
    $rose(o_job_active) && !i_cable_mode |-> $past(i_style_strobe, 2))
    else $error("no strobe");
  a_style_capture: assert property (
    $rose(o_job_active) && !i_cable_mode |-> o_job_style == $past(i_style, 2))
    else $error("bad capture");
  a_cable_style: assert property (
    $rose(o_job_active) && i_cable_mode |-> o_job_style == `CABLE_STYLE)
    else $error("cable style");
  a_purge_flag: assert property (
    o_job_active |-> o_purge == (o_job_style == `PURGE_STYLE))
    else $error("purge flag");
  a_result_set: assert property ($fell(o_job_active) |->
    o_vol_ok == o_no_error && o_no_alarm == !$past(i_alarm, 2)
    && o_disp_vol == $past(i_meas_vol, 2)) else $error("results");
  a_ready_gap: assert property (
    $fell(o_job_active) |-> !o_plate_ready [*8]) else $error("no gap");
  a_static_hold: assert property (
    (shut && i_pc_mode == `MODE_STATIC) [*4] |-> o_hold_static)
    else $error("no hold");
  a_dyn_closed: assert property (
    (shut && i_pc_mode == `MODE_DYNAMIC) [*4] |-> o_scale_sel == `SEL_CLOSED)
    else $error("closed scale");
  a_dyn_opening: assert property (
    o_job_active && i_pc_mode == `MODE_DYNAMIC && $rose(|i_valve_on)
    |-> ##[2:6] o_scale_sel == `SEL_OPENING) else $error("opening");
  a_valve_one: assert property (
    (shut && i_pc_mode == `MODE_VALVE1) [*4]
    |-> o_scale_valves == {{(NV-1){1'b0}}, 1'b1}) else $error("valve one");
  a_gateway_sel: assert property (
    (shut && i_pc_mode == `MODE_GATEWAY && $stable(i_pc_req)) [*4]
    |-> o_scale_valves == i_pc_req) else $error("gateway sel");
  a_style_echo: assert property (
    $stable(i_style) [*5] |-> o_style_echo == i_style) else $error("echo");
  a_strobe_cancel: assert property (
    $fell(i_style_strobe) && o_job_active && !i_job_done
    |-> ##[1:6] !o_job_active) else $error("no cancel");
  c_start: cover property ($rose(o_job_active));
  c_cancel: cover property ($fell(i_style_strobe) && o_job_active);
  c_opening: cover property (o_scale_sel == `SEL_OPENING);
  c_cable: cover property ($rose(o_job_active) && i_cable_mode);
endmodule
bind dispense_job_handshake job_handshake_sva #(.NV(NV)) u_sva (.*);
`default_nettype wire

// ---- verif/test_dispense_job_handshake.sv ----
// Self-checking bench for the job handshake block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "job_handshake_consts.vh"
module test_dispense_job_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0]  sty;
    logic        ok;
    logic        na;
    logic [23:0] vol;
    bit          full;
  } note_t;
  note_t q[$];      // Expected results in job order
  note_t nt;        // Oldest note being compared
  int    error_cnt = 0;
  int    checks_done = 0;
  int    seed = 58386;
  logic  was_act = 1'b0;
  wire logic [7:0]  i_style, o_style_echo, o_job_style;
  wire logic [3:0]  i_valve_on, o_scale_valves;
  wire logic        i_style_strobe, i_job_done, o_plate_ready, o_job_active;
  wire logic        o_purge, o_no_alarm, o_no_error, o_vol_ok, o_error;
  wire logic        o_advisory, o_hold_static;
  wire logic [1:0]  o_scale_sel;
  wire logic [23:0] o_disp_vol;
  logic [23:0] i_cfg_target, i_meas_vol;
  logic [15:0] i_end_ms, i_open_ms;
  logic [7:0]  i_cfg_style, i_cfg_tol;
  logic [3:0]  i_pc_req;
  logic [1:0]  i_pc_mode;
  logic        i_cfg_we, i_alarm, i_timer_end, i_cable_trig, i_cable_mode;
  logic        i_gw_present, i_sys_clk, i_rst_n;
  // Short millisecond so timers fit the run
  dispense_job_handshake #(.NV(4), .CLK_PER_MS(20), .PREP_MS(2),
    .GAP_MS(2), .HELD_MS(2)) dut (.*);
  auto_ctrl_model #(.NV(4)) ctrl (
    .i_sys_clk     (i_sys_clk),
    .i_plate_ready (o_plate_ready),
    .i_job_active  (o_job_active),
    .o_style       (i_style),
    .o_strobe      (i_style_strobe),
    .o_done        (i_job_done),
    .o_valves      (i_valve_on)
  );
  // 20 MHz clock
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cable trigger starts a style-one job that only the timer ends
  task automatic cable_run;
    i_cable_mode = 1'b1;
    ctrl.wait_on(1'b1, 1'b1, 3000);
    @(negedge i_sys_clk);
    i_cable_trig = 1'b1;
    ctrl.wait_on(1'b0, 1'b1, 20);
    i_cable_trig = 1'b0;
    ctrl.wait_on(1'b0, 1'b0, 400);
    @(negedge i_sys_clk);
    i_cable_mode = 1'b0;
  endtask
  // Load a style, note the expected results, run one job
  task automatic job(input logic [7:0] sty, input int kind);
    logic [23:0] tgt;
    logic [7:0]  tl;
    int          d;
    note_t       e;
    tgt = 24'h000400 + 24'($random(seed) & 32'h3FF);
    tl = 8'h05 + 8'($random(seed) & 32'hF);
    d = $random(seed) % 256;
    i_cfg_we = 1'b1;
    i_cfg_style = sty;
    i_cfg_target = tgt;
    i_cfg_tol = tl;
    if (kind != 1)
      i_meas_vol = tgt + 24'(d);
    if (kind != 1)
      i_alarm = 1'($random(seed));
    @(negedge i_sys_clk);
    i_cfg_we = 1'b0;
    e.sty = sty;
    e.vol = i_meas_vol;
    e.ok = ((d < 0 ? -d : d) <= (int'(tgt) * int'(tl)) / 100);
    e.na = !i_alarm;
    e.full = (kind != 1);
    q.push_back(e);
    if (kind == 4)
      cable_run();
    else
      ctrl.run_job(sty, 4'($random(seed)) | 4'h1, kind);
  endtask
  // Results appear when the active flag falls
  always @(negedge i_sys_clk)
  begin
    if (was_act && o_job_active === 1'b0 && q.size() > 0)
    begin
      nt = q.pop_front();
      check(o_job_style, nt.sty);
      if (nt.full)
      begin
        check(o_disp_vol, nt.vol);
        check(o_vol_ok, nt.ok);
        check(o_no_error, nt.ok);
        check(o_no_alarm, nt.na);
        check(o_error, !nt.ok);
      end
    end
    was_act = (o_job_active === 1'b1);
  end
  // Main sequence
  initial
  begin
    {i_rst_n, i_cfg_we, i_alarm, i_timer_end, i_cable_trig} = 5'h00;
    {i_cable_mode, i_gw_present, i_pc_req, i_pc_mode} = 8'h40;
    {i_cfg_style, i_cfg_tol, i_cfg_target, i_meas_vol} = 64'h0;
    i_end_ms = 16'h0002;
    i_open_ms = 16'h0001;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst_n = 1'b1;
    @(negedge i_sys_clk);
    check(o_plate_ready, 1'b1);
    for (int m = 0; m < 4; m++)
    begin
      i_pc_mode = 2'(m);
      i_pc_req = 4'($random(seed));
      job(8'($random(seed)) | 8'h02, 0);
    end
    job(`PURGE_STYLE, 0);
    i_timer_end = 1'b1;
    job(8'h05, 2);
    check(o_advisory, 1'b0);
    i_timer_end = 1'b0;
    job(`CABLE_STYLE, 4);
    job(8'h06, 1);
    check(o_advisory, 1'b1);
    job(8'h07, 3);
    check(o_advisory, 1'b1);
    repeat (4) @(negedge i_sys_clk);
    check(q.size(), 0);
    summarize();
  end
  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    error_cnt++;
    summarize();
  end
endmodule
`default_nettype wire
